// ==== include/codec_ctrl_pkg.sv ====
// Functional notes
// - Pointer bit 7 set makes the index step by one after each data byte.
// - Reset clears pointer, reserved byte, both control bytes and both attenuators.
// - Two ADC bits bypass the right and left input high-pass filters.
// - Calibration starts on leaving reset and when the calibration bit goes from 0 to 1.
// - Attenuator code counts half-dB steps upward; zero means no attenuation.
// - Attenuator code above 227 fully mutes that output.
// - Pointer low bits select the register the next data byte lands in.
// - Calibration status reads 1 while calibrating, 0 when done.
// - Clock fault and calibration status bits ignore host writes.
// - ADC and DAC power bits power down each side; both means whole chip.
package codec_ctrl_pkg;

  localparam int         SYS_CLK_HZ     = 20_000_000;
  localparam int         CAL_TIME_MS    = 50;
  localparam int         CAL_CYCLES     = CAL_TIME_MS * (SYS_CLK_HZ / 1000);
  localparam logic [6:0] CHIP_ADDR      = 7'h10;
  localparam logic [2:0] IDX_RESERVED   = 3'h0;
  localparam logic [2:0] IDX_ADC        = 3'h1;
  localparam logic [2:0] IDX_DAC        = 3'h2;
  localparam logic [2:0] IDX_ATT_FIRST  = 3'h3;
  localparam logic [2:0] IDX_ATT_SECOND = 3'h4;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [7:0] MUTE_LIMIT     = 8'hE3;
  localparam logic [7:0] ADC_RO_MASK    = 8'h03;

  typedef struct packed {
    logic       pointer_auto_step;
    logic [3:0] zero;
    logic [2:0] pointer_index_field;
  } pointer_t;

  typedef struct packed {
    logic adc_power_off;
    logic right_highpass_bypass;
    logic left_highpass_bypass;
    logic right_input_mute;
    logic left_input_mute;
    logic calibration_start;
    logic calibration_running;
    logic clocking_fault;
  } adc_ctrl_t;

  typedef struct packed {
    logic       dac_power_off;
    logic       zero_mute_off;
    logic       right_output_mute;
    logic       left_output_mute;
    logic       soft_ramp;
    logic       zero;
    logic [1:0] ramp_rate;
  } dac_ctrl_t;

  typedef enum logic [3:0] {
    ST_ADDR   = 4'h1,
    ST_PTR    = 4'h2,
    ST_DATA   = 4'h4,
    ST_IGNORE = 4'h8
  } port_state_t;

endpackage

// ==== rtl/codec_control_registers.sv ====
module codec_control_registers #(
  parameter int CAL_CYCLES = codec_ctrl_pkg::CAL_CYCLES
) (
  // Clock and reset
  input  wire logic                sys_clk_i,
  input  wire logic                rst_n_i,
  // Control port pins
  input  wire logic                ctrl_cs_n_i,
  input  wire logic                ctrl_clk_i,
  input  wire logic                ctrl_data_i,
  // Converter status
  input  wire logic                clock_fault_i,
  // Register contents
  output codec_ctrl_pkg::pointer_t  pointer_o,
  output logic [7:0]                reserved_byte_o,
  output codec_ctrl_pkg::adc_ctrl_t adc_ctrl_o,
  output codec_ctrl_pkg::dac_ctrl_t dac_ctrl_o,
  output logic [7:0]                att_first_o,
  output logic [7:0]                att_second_o,
  // Derived controls
  output logic                      mute_first_o,
  output logic                      mute_second_o,
  output logic                      chip_power_off_o
);

  localparam int CW = $clog2(CAL_CYCLES + 1);
  localparam logic [CW-1:0] CAL_LAST = CW'(CAL_CYCLES - 1);

  logic cs_n_clean;
  logic cclk_clean;
  logic data_clean;

  pin_sync cs_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (ctrl_cs_n_i),
    .level_o   (cs_n_clean)
  );

  pin_sync clk_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (ctrl_clk_i),
    .level_o   (cclk_clean)
  );

  pin_sync data_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (ctrl_data_i),
    .level_o   (data_clean)
  );

  // Serial port state
  codec_ctrl_pkg::port_state_t state;
  codec_ctrl_pkg::port_state_t next_state;
  logic [6:0]                  shift;
  logic [6:0]                  next_shift;
  logic [2:0]                  bit_cnt;
  logic [2:0]                  next_bit_cnt;
  logic                        cclk_prev;
  logic                        clk_rise;
  logic                        byte_done;
  logic [7:0]                  byte_val;
  logic                        data_write;

  assign clk_rise  = cclk_clean & ~cclk_prev & ~cs_n_clean;
  assign byte_done = clk_rise & (bit_cnt == codec_ctrl_pkg::BIT_LAST);
  assign byte_val  = {shift, data_clean};
  assign data_write = byte_done & (state == codec_ctrl_pkg::ST_DATA);

  always_comb begin
    next_state   = state;
    next_shift   = shift;
    next_bit_cnt = bit_cnt;
    if (cs_n_clean) begin
      next_state   = codec_ctrl_pkg::ST_ADDR;
      next_bit_cnt = 3'h0;
    end else if (clk_rise) begin
      next_shift   = byte_val[6:0];
      next_bit_cnt = bit_cnt + 3'h1;
      if (byte_done) begin
        case (state)
          codec_ctrl_pkg::ST_ADDR: begin
            if (byte_val == {codec_ctrl_pkg::CHIP_ADDR, 1'b0}) begin
              next_state = codec_ctrl_pkg::ST_PTR;
            end else begin
              next_state = codec_ctrl_pkg::ST_IGNORE;
            end
          end
          codec_ctrl_pkg::ST_PTR: next_state = codec_ctrl_pkg::ST_DATA;
          codec_ctrl_pkg::ST_DATA: next_state = codec_ctrl_pkg::ST_DATA;
          default: next_state = codec_ctrl_pkg::ST_IGNORE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state     <= codec_ctrl_pkg::ST_ADDR;
      shift     <= 7'h00;
      bit_cnt   <= 3'h0;
      cclk_prev <= 1'b1;
    end else begin
      state     <= next_state;
      shift     <= next_shift;
      bit_cnt   <= next_bit_cnt;
      cclk_prev <= cclk_clean;
    end
  end

  // Register file and calibration
  codec_ctrl_pkg::pointer_t  next_pointer;
  codec_ctrl_pkg::adc_ctrl_t next_adc;
  codec_ctrl_pkg::dac_ctrl_t next_dac;
  logic [7:0]                next_reserved;
  logic [7:0]                next_att_first;
  logic [7:0]                next_att_second;
  logic                      cal_prev;
  logic                      cal_running;
  logic                      next_cal_running;
  logic [CW-1:0]             cal_count;
  logic [CW-1:0]             next_cal_count;
  logic                      cal_start;
  logic                      fault_q;
  logic [2:0]                idx;

  assign idx       = pointer_o.pointer_index_field;
  assign cal_start = adc_ctrl_o.calibration_start & ~cal_prev;

  always_comb begin
    next_cal_running = cal_running;
    next_cal_count   = cal_count;
    if (cal_start) begin
      next_cal_running = 1'b1;
      next_cal_count   = '0;
    end else if (cal_running) begin
      if (cal_count == CAL_LAST) begin
        next_cal_running = 1'b0;
      end else begin
        next_cal_count = cal_count + CW'(1);
      end
    end
  end

  always_comb begin
    next_pointer    = pointer_o;
    next_reserved   = reserved_byte_o;
    next_adc        = adc_ctrl_o;
    next_dac        = dac_ctrl_o;
    next_att_first  = att_first_o;
    next_att_second = att_second_o;
    if (byte_done && state == codec_ctrl_pkg::ST_PTR) begin
      next_pointer = {byte_val[7], 4'h0, byte_val[2:0]};
    end
    if (data_write) begin
      if (idx == codec_ctrl_pkg::IDX_RESERVED) begin
        next_reserved = byte_val;
      end else if (idx == codec_ctrl_pkg::IDX_ADC) begin
        next_adc = byte_val & ~codec_ctrl_pkg::ADC_RO_MASK;
      end else if (idx == codec_ctrl_pkg::IDX_DAC) begin
        next_dac = byte_val;
      end else if (idx == codec_ctrl_pkg::IDX_ATT_FIRST) begin
        next_att_first = byte_val;
      end else if (idx == codec_ctrl_pkg::IDX_ATT_SECOND) begin
        next_att_second = byte_val;
      end
      if (pointer_o.pointer_auto_step) begin
        next_pointer.pointer_index_field = idx + 3'h1;
      end
    end
    next_adc.calibration_running = cal_running;
    next_adc.clocking_fault      = fault_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pointer_o        <= codec_ctrl_pkg::RESET_BYTE;
      reserved_byte_o  <= codec_ctrl_pkg::RESET_BYTE;
      adc_ctrl_o       <= codec_ctrl_pkg::RESET_BYTE;
      dac_ctrl_o       <= codec_ctrl_pkg::RESET_BYTE;
      att_first_o      <= codec_ctrl_pkg::RESET_BYTE;
      att_second_o     <= codec_ctrl_pkg::RESET_BYTE;
      mute_first_o     <= 1'b0;
      mute_second_o    <= 1'b0;
      chip_power_off_o <= 1'b0;
      cal_prev         <= 1'b0;
      cal_running      <= 1'b1;
      cal_count        <= '0;
      fault_q          <= 1'b0;
    end else begin
      pointer_o        <= next_pointer;
      reserved_byte_o  <= next_reserved;
      adc_ctrl_o       <= next_adc;
      dac_ctrl_o       <= next_dac;
      att_first_o      <= next_att_first;
      att_second_o     <= next_att_second;
      mute_first_o     <= next_att_first > codec_ctrl_pkg::MUTE_LIMIT;
      mute_second_o    <= next_att_second > codec_ctrl_pkg::MUTE_LIMIT;
      chip_power_off_o <= next_adc.adc_power_off & next_dac.dac_power_off;
      cal_prev         <= adc_ctrl_o.calibration_start;
      cal_running      <= next_cal_running;
      cal_count        <= next_cal_count;
      fault_q          <= clock_fault_i;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence data_byte_s;
    data_write;
  endsequence

  sequence adc_write_s;
    data_write && idx == codec_ctrl_pkg::IDX_ADC;
  endsequence

  ptr_fixed_a: assert property (
    (data_byte_s and !pointer_o.pointer_auto_step) |=> $stable(idx))
    else $error("pointer moved without auto step");

  ptr_step_a: assert property (
    (data_byte_s and pointer_o.pointer_auto_step) |=> idx == $past(idx) + 3'h1)
    else $error("pointer did not step");

  reset_zero_a: assert property (disable iff (1'b0)
    !rst_n_i |=> att_first_o == 8'h00 && att_second_o == 8'h00
      && dac_ctrl_o == 8'h00 && pointer_o == 8'h00 && reserved_byte_o == 8'h00)
    else $error("register not cleared by reset");

  hp_bypass_a: assert property (
    adc_write_s |=> adc_ctrl_o.right_highpass_bypass == $past(byte_val[6])
      && adc_ctrl_o.left_highpass_bypass == $past(byte_val[5]))
    else $error("high-pass bypass bits not stored");

  cal_start_a: assert property (
    cal_start |=> cal_running ##1 adc_ctrl_o.calibration_running)
    else $error("calibration did not start");

  cal_hold_a: assert property (
    !cal_start && !cal_running |=> !cal_running)
    else $error("calibration started without a rising edge");

  att_store_a: assert property (
    (data_byte_s and idx == codec_ctrl_pkg::IDX_ATT_FIRST)
      |=> att_first_o == $past(byte_val))
    else $error("attenuation code not stored");

  mute_limit_a: assert property (
    mute_first_o == (att_first_o > 8'hE3)
      && mute_second_o == (att_second_o > 8'hE3))
    else $error("mute does not follow attenuation code");

  dac_target_a: assert property (
    (data_byte_s and idx == codec_ctrl_pkg::IDX_DAC)
      |=> dac_ctrl_o == $past(byte_val))
    else $error("data byte missed the pointed register");

  cal_end_a: assert property (
    cal_running && !cal_start && cal_count == CAL_LAST
      |=> !cal_running ##1 !adc_ctrl_o.calibration_running)
    else $error("calibration status did not clear");

  ro_bits_a: assert property (
    adc_write_s |=> adc_ctrl_o.calibration_running == $past(cal_running)
      && adc_ctrl_o.clocking_fault == $past(fault_q))
    else $error("read-only bit took a host write");

  chip_off_a: assert property (
    chip_power_off_o == (adc_ctrl_o.adc_power_off & dac_ctrl_o.dac_power_off))
    else $error("chip power-down mismatch");

endmodule

// ==== rtl/pin_sync.sv ====
module pin_sync (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // Raw pin and cleaned level
  input  wire logic pin_i,
  output logic      level_o
);

  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       next_level;

  // Level moves once second and third stages agree
  always_comb begin
    next_stage = {stage[1:0], pin_i};
    next_level = level_o;
    if (stage[1] == stage[2]) begin
      next_level = stage[2];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      stage   <= 3'h7;
      level_o <= 1'b1;
    end else begin
      stage   <= next_stage;
      level_o <= next_level;
    end
  end

endmodule

// ==== tb/codec_control_registers_tb.sv ====
module codec_control_registers_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CAL = 20;
  typedef struct {int sel; logic [7:0] val;} note_t;
  logic                      sys_clk;
  logic                      rst_n;
  logic                      cs_n;
  logic                      cclk;
  logic                      cdata;
  logic                      clk_fault;
  codec_ctrl_pkg::pointer_t  pointer;
  logic [7:0]                rsv;
  codec_ctrl_pkg::adc_ctrl_t adc;
  codec_ctrl_pkg::dac_ctrl_t dac;
  logic [7:0]                att1;
  logic [7:0]                att2;
  logic                      mute1;
  logic                      mute2;
  logic                      chip_off;
  logic [7:0]                fb [8];
  logic [7:0]                lfsr;
  logic [7:0]                code;
  logic [7:0]                other;
  int                        error_cnt;
  int                        comparisons;
  note_t                     note_q [$];
  note_t                     cur;
  event                      check_ev;
  logic [7:0] codes [4] = '{8'h00, 8'hE3, 8'hE4, 8'hFF};
  string names [8] = '{"pointer", "reserved", "adc", "dac",
                       "att_first", "att_second", "mutes", "chip_off"};

  codec_control_registers #(.CAL_CYCLES(CAL)) codec_control_registers_inst (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .ctrl_cs_n_i(cs_n),
    .ctrl_clk_i(cclk), .ctrl_data_i(cdata), .clock_fault_i(clk_fault),
    .pointer_o(pointer), .reserved_byte_o(rsv), .adc_ctrl_o(adc),
    .dac_ctrl_o(dac), .att_first_o(att1), .att_second_o(att2),
    .mute_first_o(mute1), .mute_second_o(mute2),
    .chip_power_off_o(chip_off));

  spi_host_model spi_host_model_inst (
    .sys_clk_i(sys_clk), .ctrl_cs_n_o(cs_n), .ctrl_clk_o(cclk),
    .ctrl_data_o(cdata));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [7:0] observe(input int sel);
    case (sel)
      0: return pointer;
      1: return rsv;
      2: return adc;
      3: return dac;
      4: return att1;
      5: return att2;
      6: return {6'h00, mute2, mute1};
      default: return {7'h00, chip_off};
    endcase
  endfunction

  task automatic compare_byte(input string what, input logic [7:0] exp,
                              input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic note(input int sel, input logic [7:0] val);
    note_q.push_back('{sel, val});
  endtask

  task automatic flush();
    ->check_ev;
    @(negedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d0,
                    input logic [7:0] d1, input int n);
    fb[0] = 8'h20;
    fb[1] = ptr;
    fb[2] = d0;
    fb[3] = d1;
    spi_host_model_inst.send_frame(fb, n + 2);
  endtask

  task automatic wait_cal();
    int i;
    for (i = 0; i < 100; i++) begin
      if (adc.calibration_running === 1'b0) break;
      @(negedge sys_clk);
    end
    if (i == 100) begin
      error_cnt++;
      $display("Error calibration expected done seen busy");
      summarize();
    end
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    // Cleared contents checked while reset still holds them
    for (int s = 0; s < 8; s++) note(s, 8'h00);
    flush();
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    note(2, 8'h02);
    flush();
    wait_cal();
  endtask

  // Takes the oldest notes when a result is due
  initial begin
    forever begin
      @(check_ev);
      while (note_q.size() > 0) begin
        cur = note_q.pop_front();
        compare_byte(names[cur.sel], cur.val, observe(cur.sel));
      end
    end
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    summarize();
  end

  initial begin
    clk_fault = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    lfsr = 8'h33;
    do_reset();
    // Block write from index 0 running past the last register
    lfsr = step(lfsr);
    fb[4] = {1'b0, lfsr[6:0]};
    fb[5] = 8'h10;
    fb[6] = 8'hE4;
    fb[7] = 8'h5A;
    wr(8'h80, 8'h00, 8'h60, 6);
    note(1, 8'h00);
    note(2, 8'h60);
    note(3, fb[4]);
    note(4, 8'h10);
    note(5, 8'hE4);
    note(6, 8'h02);
    note(0, 8'h86);
    flush();
    for (int i = 0; i < 6; i++) begin
      lfsr = step(lfsr);
      code = (i < 4) ? codes[i] : lfsr;
      lfsr = step(lfsr);
      other = lfsr;
      wr(8'h83, code, other, 2);
      note(4, code);
      note(5, other);
      note(6, {6'h00, other > 8'hE3, code > 8'hE3});
      note(0, 8'h85);
      flush();
    end
    wr(8'h04, 8'h11, 8'h22, 2);
    note(5, 8'h22);
    note(4, code);
    note(0, 8'h04);
    flush();
    // Right chip address with the low address-byte bit set is ignored
    fb[0] = 8'h21;
    spi_host_model_inst.send_frame(fb, 3);
    note(4, code);
    flush();
    clk_fault = 1'b1;
    wr(8'h01, 8'h03, 8'h00, 1);
    note(2, 8'h01);
    flush();
    clk_fault = 1'b0;
    repeat (3) @(negedge sys_clk);
    note(2, 8'h00);
    flush();
    wr(8'h01, 8'h04, 8'h00, 1);
    note(2, 8'h06);
    flush();
    wait_cal();
    note(2, 8'h04);
    flush();
    wr(8'h01, 8'h04, 8'h00, 1);
    note(2, 8'h04);
    flush();
    wr(8'h01, 8'h00, 8'h04, 2);
    note(2, 8'h06);
    flush();
    wait_cal();
    for (int p = 0; p < 4; p++) begin
      wr(8'h81, {p[1], 7'h00}, {p[0], 7'h00}, 2);
      note(7, {7'h00, p[1] & p[0]});
      note(2, {p[1], 7'h00});
      flush();
    end
    do_reset();
    summarize();
  end
endmodule

// ==== tb/spi_host_model.sv ====
module spi_host_model (
  // Clock for pacing
  input  wire logic sys_clk_i,
  // Control port pins
  output logic      ctrl_cs_n_o,
  output logic      ctrl_clk_o,
  output logic      ctrl_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Four cycles each phase gives a 400 ns bit clock
  localparam int HALF = 4;

  initial begin
    ctrl_cs_n_o = 1'b1;
    ctrl_clk_o  = 1'b1;
    ctrl_data_o = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // Bytes go out MSB first, data changes while the clock is low
  task automatic send_frame(input logic [7:0] b [8], input int n);
    ctrl_cs_n_o = 1'b0;
    wait_cyc(HALF);
    for (int i = 0; i < n; i++) begin
      for (int k = 7; k >= 0; k--) begin
        ctrl_clk_o  = 1'b0;
        ctrl_data_o = b[i][k];
        wait_cyc(HALF);
        ctrl_clk_o  = 1'b1;
        wait_cyc(HALF);
      end
    end
    ctrl_cs_n_o = 1'b1;
    // Deselected line no longer shows the last bit
    ctrl_data_o = ~ctrl_data_o;
    wait_cyc(HALF);
  endtask
endmodule
